// ===== logic/fdas_slave_port.sv
/*
  AXI slave port of the fabric DRAM subsystem: takes fabric read and write bursts and
  turns them into single-beat requests on the memory controller port.
  Assumes a memory side that answers one read at a time and accepts writes with strobes.
*/
`timescale 1ns/1ps
module fdas_slave_port
  import fdas_pkg::*;
#(
  parameter fdas_pkg::fdas_bus_t BUS_MODE = fdas_pkg::FDAS_BUS_AXI
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // read address channel
  input wire logic [fdas_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [fdas_pkg::BURST_W-1:0] s_axi_arburst,
  input wire logic [fdas_pkg::SIZE_W-1:0] s_axi_arsize,
  input wire logic [fdas_pkg::LEN_W-1:0] s_axi_arlen,
  input wire logic [fdas_pkg::ID_W-1:0] s_axi_arid,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [fdas_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [fdas_pkg::ID_W-1:0] s_axi_rid,
  output logic [fdas_pkg::RESP_W-1:0] s_axi_rresp,
  output logic s_axi_rlast,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // write address channel
  input wire logic [fdas_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [fdas_pkg::BURST_W-1:0] s_axi_awburst,
  input wire logic [fdas_pkg::SIZE_W-1:0] s_axi_awsize,
  input wire logic [fdas_pkg::LEN_W-1:0] s_axi_awlen,
  input wire logic [fdas_pkg::ID_W-1:0] s_axi_awid,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [fdas_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [fdas_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wlast,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [fdas_pkg::ID_W-1:0] s_axi_bid,
  output logic [fdas_pkg::RESP_W-1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // memory controller request
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic mem_req_write,
  output logic [fdas_pkg::ADDR_W-1:0] mem_req_addr,
  output logic [fdas_pkg::DATA_W-1:0] mem_req_wdata,
  output logic [fdas_pkg::STRB_W-1:0] mem_req_wstrb,
  // memory controller read return
  input wire logic mem_rsp_valid,
  input wire logic [fdas_pkg::DATA_W-1:0] mem_rsp_data,
  input wire logic mem_rsp_err
);
  import fdas_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////
  // configuration

  // outside AXI mode the whole port is held quiet: no ready, no valid, no memory traffic
  localparam bit IS_AXI = (BUS_MODE == FDAS_BUS_AXI);

  if (DATA_W != 64 || ID_W != 4 || ADDR_W != 32) begin : g_bad_widths
    $error("fdas_slave_port supports only 64-bit data, 4-bit IDs and 32-bit addresses");
  end

  if (BUS_MODE != FDAS_BUS_AXI && BUS_MODE != FDAS_BUS_AHB) begin : g_bad_mode
    $error("fdas_slave_port serves only the AXI and AHB bus modes");
  end

  // the reserved burst code is refused on both channels, so one decode serves both
  function automatic logic burst_reserved(input logic [BURST_W-1:0] kind);
    burst_reserved = (kind == BURST_RSVD);
  endfunction : burst_reserved

  ////////////////////////////////////////////////////////////////////////////////////////
  // state and transaction context

  fdas_state_t state;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] next_addr;
  logic [BURST_W-1:0] cur_burst;
  logic [SIZE_W-1:0] cur_size;
  logic [LEN_W-1:0] cur_len;
  logic [LEN_W-1:0] beat;
  logic [ID_W-1:0] txn_id;
  logic prefer_rd;
  logic wr_last;
  logic wr_err;
  logic rd_rsvd;

  logic ar_take;
  logic aw_take;
  logic rd_fire;
  logic w_fire;
  logic mem_fire;

  // read and write share one memory port; on a tie the two channels take turns
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign rd_fire = s_axi_rvalid && s_axi_rready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign mem_fire = mem_req_valid && mem_req_ready;

  ////////////////////////////////////////////////////////////////////////////////////////
  // handshake outputs

  always_comb begin
    s_axi_arready = IS_AXI && (state == ST_IDLE) && (!s_axi_awvalid || prefer_rd);
    s_axi_awready = IS_AXI && (state == ST_IDLE) && !(s_axi_arvalid && prefer_rd);
    s_axi_wready = (state == ST_WR_DATA);
    s_axi_rvalid = (state == ST_RD_DATA);
    s_axi_bvalid = (state == ST_WR_RESP);
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // memory request outputs

  // one beat per request: the port never has two memory accesses outstanding
  always_comb begin
    mem_req_valid = (state == ST_RD_REQ) || (state == ST_WR_MEM);
    mem_req_write = (state == ST_WR_MEM);
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ar_take) begin
            // a reserved burst type never reaches memory; it is answered with errors
            state <= burst_reserved(s_axi_arburst) ? ST_RD_DATA : ST_RD_REQ;
          end else if (aw_take) begin
            state <= ST_WR_DATA;
          end
        end
        ST_RD_REQ: begin
          if (mem_req_ready) begin
            state <= ST_RD_WAIT;
          end
        end
        ST_RD_WAIT: begin
          if (mem_rsp_valid) begin
            state <= ST_RD_DATA;
          end
        end
        ST_RD_DATA: begin
          if (rd_fire) begin
            if (s_axi_rlast) begin
              state <= ST_IDLE;
            end else if (!rd_rsvd) begin
              state <= ST_RD_REQ;
            end
          end
        end
        ST_WR_DATA: begin
          if (w_fire) begin
            if (!burst_reserved(cur_burst)) begin
              state <= ST_WR_MEM;
            end else if (fdas_is_last(beat, cur_len)) begin
              state <= ST_WR_RESP;
            end
          end
        end
        ST_WR_MEM: begin
          if (mem_req_ready) begin
            state <= wr_last ? ST_WR_RESP : ST_WR_DATA;
          end
        end
        ST_WR_RESP: begin
          if (s_axi_bready) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prefer_rd <= 1'b0;
    end else if (ar_take) begin
      prefer_rd <= 1'b0;
    end else if (aw_take) begin
      prefer_rd <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // burst context and beat address

  fdas_addr_step u_addr_step (
    .addr(cur_addr),
    .burst(cur_burst),
    .size(cur_size),
    .len(cur_len),
    .next_addr(next_addr)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur_addr <= ADDR_RESET;
      cur_burst <= BURST_INCR;
      cur_size <= 2'h0;
      cur_len <= BEAT_RESET;
      txn_id <= ID_RESET;
      rd_rsvd <= 1'b0;
    end else if (ar_take) begin
      cur_addr <= s_axi_araddr;
      cur_burst <= s_axi_arburst;
      cur_size <= s_axi_arsize;
      cur_len <= s_axi_arlen;
      txn_id <= s_axi_arid;
      rd_rsvd <= burst_reserved(s_axi_arburst);
    end else if (aw_take) begin
      cur_addr <= s_axi_awaddr;
      cur_burst <= s_axi_awburst;
      cur_size <= s_axi_awsize;
      cur_len <= s_axi_awlen;
      txn_id <= s_axi_awid;
      rd_rsvd <= 1'b0;
    end else if (rd_fire || (mem_fire && mem_req_write)) begin
      cur_addr <= next_addr;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      beat <= BEAT_RESET;
    end else if (ar_take || aw_take) begin
      beat <= BEAT_RESET;
    end else if (rd_fire || w_fire) begin
      beat <= beat + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // read data path

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rdata <= DATA_RESET;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rlast <= 1'b0;
    end else if (ar_take) begin
      // only the reserved-burst path uses these values straight away
      s_axi_rdata <= DATA_RESET;
      s_axi_rresp <= RESP_SLVERR;
      s_axi_rlast <= (s_axi_arlen == BEAT_RESET);
    end else if ((state == ST_RD_WAIT) && mem_rsp_valid) begin
      s_axi_rdata <= mem_rsp_data;
      s_axi_rresp <= mem_rsp_err ? RESP_SLVERR : RESP_OKAY;
      s_axi_rlast <= fdas_is_last(beat, cur_len);
    end else if (rd_fire && rd_rsvd && !s_axi_rlast) begin
      s_axi_rlast <= fdas_is_last(beat + 4'h1, cur_len);
    end
  end

  // the tag is captured with the address and held for every beat and the response
  assign s_axi_rid = txn_id;
  assign s_axi_bid = txn_id;

  ////////////////////////////////////////////////////////////////////////////////////////
  // write data path

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mem_req_wdata <= DATA_RESET;
      mem_req_wstrb <= 8'h00;
      wr_last <= 1'b0;
    end else if (w_fire) begin
      mem_req_wdata <= s_axi_wdata;
      mem_req_wstrb <= s_axi_wstrb;
      // the beat count, not the master's last flag, decides where the burst ends
      wr_last <= fdas_is_last(beat, cur_len);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_err <= 1'b0;
    end else if (aw_take) begin
      wr_err <= burst_reserved(s_axi_awburst);
    end else if (w_fire && (s_axi_wlast != fdas_is_last(beat, cur_len))) begin
      wr_err <= 1'b1;
    end
  end

  assign s_axi_bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
  assign mem_req_addr = cur_addr;

endmodule : fdas_slave_port

// ===== logic/fdas_pkg.sv
/*
  Shared constants, types and helpers for the fabric DRAM subsystem AXI slave port.
  Assumes a single 40 MHz clock domain and a one-beat memory request port behind the slave.
*/
// Functional notes
// - slave port logic exists only when the subsystem is built for AXI; an AHB build still has the port, held quiet with no ready or valid
// - read address ready is active high; 1 accepts address and control
// - write address ready is active high; 1 accepts address and control
// - write response carries the 4-bit ID of the answered write
// - write status codes: okay, exclusive okay, slave error, decode error
// - write response valid is high only while a response is presented
// - every read beat carries the 4-bit ID of its read address
// - read last is high only on the final beat of each burst
// - read status codes: okay, exclusive okay, slave error, decode error
// - read valid is high only while 64-bit read data is presented
// - write data ready is active high; 1 accepts write data this cycle
// - burst type fixed, incrementing or wrapping steers each beat address
package fdas_pkg;

  localparam int ID_W = 4;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int STRB_W = DATA_W / 8;
  localparam int LEN_W = 4;
  localparam int SIZE_W = 2;
  localparam int BURST_W = 2;
  localparam int RESP_W = 2;

  localparam logic [BURST_W-1:0] BURST_FIXED = 2'h0;
  localparam logic [BURST_W-1:0] BURST_INCR = 2'h1;
  localparam logic [BURST_W-1:0] BURST_WRAP = 2'h2;
  localparam logic [BURST_W-1:0] BURST_RSVD = 2'h3;

  localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
  localparam logic [RESP_W-1:0] RESP_EXOKAY = 2'h1;
  localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
  localparam logic [RESP_W-1:0] RESP_DECERR = 2'h3;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 64'h0000_0000_0000_0000;
  localparam logic [ID_W-1:0] ID_RESET = 4'h0;
  localparam logic [LEN_W-1:0] BEAT_RESET = 4'h0;

  typedef enum {FDAS_BUS_AXI, FDAS_BUS_AHB} fdas_bus_t;

  typedef enum {
    ST_IDLE, ST_RD_REQ, ST_RD_WAIT, ST_RD_DATA, ST_WR_DATA, ST_WR_MEM, ST_WR_RESP
  } fdas_state_t;

  function automatic logic fdas_is_last(input logic [LEN_W-1:0] beat,
                                        input logic [LEN_W-1:0] len);
    fdas_is_last = (beat == len);
  endfunction : fdas_is_last

endpackage : fdas_pkg

// ===== logic/fdas_addr_step.sv
/*
  Next-beat address for one AXI burst beat.
  Assumes wrapping bursts carry 2, 4, 8 or 16 beats and an aligned start, as the master must.
*/
`timescale 1ns/1ps
module fdas_addr_step
  import fdas_pkg::*;
(
  // current beat
  input wire logic [fdas_pkg::ADDR_W-1:0] addr,
  input wire logic [fdas_pkg::BURST_W-1:0] burst,
  input wire logic [fdas_pkg::SIZE_W-1:0] size,
  input wire logic [fdas_pkg::LEN_W-1:0] len,
  // following beat
  output logic [fdas_pkg::ADDR_W-1:0] next_addr
);
  import fdas_pkg::*;

  logic [ADDR_W-1:0] step;
  logic [ADDR_W-1:0] wrap_mask;
  logic [ADDR_W-1:0] bumped;

  always_comb begin
    step = 32'h0000_0001 << size;
    wrap_mask = (({28'h000_0000, len} + 32'h0000_0001) << size) - 32'h0000_0001;
    // later beats of an unaligned incrementing burst snap to the size boundary
    bumped = (addr & ~(step - 32'h0000_0001)) + step;
    case (burst)
      BURST_FIXED: next_addr = addr;
      BURST_INCR: next_addr = bumped;
      BURST_WRAP: next_addr = (addr & ~wrap_mask) | (bumped & wrap_mask);
      default: next_addr = addr;
    endcase
  end

endmodule : fdas_addr_step

// ===== testbench/fdas_slave_port_monitor.sv
/*
  Protocol checker for the fabric DRAM subsystem AXI slave port.
  Assumes it is bound to fdas_slave_port and sees only its ports.
*/
`timescale 1ns/1ps
module fdas_slave_port_monitor
  import fdas_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_arburst,
  input wire logic [3:0] s_axi_arlen,
  input wire logic [3:0] s_axi_arid,
  input wire logic [63:0] s_axi_rdata,
  input wire logic [3:0] s_axi_rid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rlast,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [3:0] s_axi_awid,
  input wire logic s_axi_wready,
  input wire logic [3:0] s_axi_bid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic mem_req_valid,
  input wire logic mem_req_write,
  input wire logic mem_rsp_valid
);
  logic [3:0] ar_tag, aw_tag, ar_len, rbeat;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // one burst in flight, so a single copy of each tag is enough
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ar_tag <= 4'h0;
      ar_len <= 4'h0;
      aw_tag <= 4'h0;
      rbeat <= 4'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_tag <= s_axi_arid;
        ar_len <= s_axi_arlen;
        rbeat <= 4'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        rbeat <= rbeat + 4'h1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_tag <= s_axi_awid;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  sequence s_ar;
    s_axi_arvalid && s_axi_arready && s_axi_arburst != BURST_RSVD;
  endsequence
  sequence s_aw;
    s_axi_awvalid && s_axi_awready;
  endsequence
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_ar_mem; s_ar |=> mem_req_valid && !mem_req_write; endproperty
  property p_aw_w; s_aw |=> s_axi_wready && !s_axi_bvalid && !s_axi_awready; endproperty
  property p_rid; s_axi_rvalid |-> s_axi_rid == ar_tag; endproperty
  property p_bid; s_axi_bvalid |-> s_axi_bid == aw_tag; endproperty
  property p_rlast; s_axi_rvalid |-> s_axi_rlast == (rbeat == ar_len); endproperty
  property p_rresp; s_axi_rvalid |-> !s_axi_rresp[0]; endproperty
  property p_bresp; s_axi_bvalid |-> !s_axi_bresp[0]; endproperty
  property p_rsp_r; mem_rsp_valid |=> s_axi_rvalid; endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rid);
  endproperty
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid [*2]; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read address taken mid burst");
  a_ar_mem: assert property (p_ar_mem) else $error("no memory read after address");
  a_aw_w: assert property (p_aw_w) else $error("write data not opened");
  a_rid: assert property (p_rid) else $error("read tag wrong");
  a_bid: assert property (p_bid) else $error("write tag wrong");
  a_rlast: assert property (p_rlast) else $error("last beat flag wrong");
  a_rresp: assert property (p_rresp) else $error("read status code wrong");
  a_bresp: assert property (p_bresp) else $error("write status code wrong");
  a_rsp_r: assert property (p_rsp_r) else $error("read data late");
  a_r_hold: assert property (p_r_hold) else $error("read beat dropped");
  a_b_once: assert property (p_b_once) else $error("second write response");
endmodule : fdas_slave_port_monitor

bind fdas_slave_port fdas_slave_port_monitor fdas_slave_port_monitor_i (.*);

// ===== testbench/fdas_mem_model.sv
/*
  Memory controller model: takes one request at a time, answers reads with a pulse.
  Assumes the port holds each request until ready; slow adds two wait cycles.
*/
`timescale 1ns/1ps
module fdas_mem_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic err_en,
  input wire logic mem_req_valid,
  input wire logic mem_req_write,
  input wire logic [31:0] mem_req_addr,
  output logic mem_req_ready,
  output logic mem_rsp_valid,
  output logic mem_rsp_err,
  output logic [63:0] mem_rsp_data
);
  logic [1:0] wait_cnt;
  assign mem_req_ready = mem_req_valid && (!slow || wait_cnt == 2'h2);
  // read data is the address and its inverse; between pulses it toggles
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 2'h0;
      mem_rsp_valid <= 1'h0;
      mem_rsp_err <= 1'h0;
      mem_rsp_data <= '0;
    end else begin
      wait_cnt <= (mem_req_valid && !mem_req_ready) ? wait_cnt + 2'h1 : 2'h0;
      mem_rsp_valid <= mem_req_ready && !mem_req_write;
      mem_rsp_err <= err_en && mem_req_ready;
      mem_rsp_data <= (mem_req_ready && !mem_req_write) ? {~mem_req_addr, mem_req_addr}
                                                        : ~mem_rsp_data;
    end
  end
endmodule : fdas_mem_model

// ===== testbench/fabric_dram_axi_slave_port_tb.sv
/*
  Self-checking bench for the AXI slave port: read bursts from a table, then writes.
  Assumes fdas_mem_model behind the port and the bound checker.
*/
`timescale 1ns/1ps
module fabric_dram_axi_slave_port_tb;
  import fdas_pkg::*;
  typedef struct packed {
    logic [1:0] b, sz; logic [3:0] ln, id; logic [31:0] a; logic slow, err; logic [1:0] rs;
  } fdas_row_t;
  logic clock = 1'h0, rst_b = 1'h0, slow = 1'h0, err_en = 1'h0;
  logic [31:0] s_axi_araddr = '0, s_axi_awaddr = '0, mem_req_addr;
  logic [1:0] s_axi_arburst = '0, s_axi_arsize = '0, s_axi_awburst = '0, s_axi_awsize = '0;
  logic [3:0] s_axi_arlen = '0, s_axi_arid = '0, s_axi_awlen = '0, s_axi_awid = '0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_wlast = 1'h0, s_axi_wvalid = 1'h0;
  logic [63:0] s_axi_wdata = '0, s_axi_rdata, mem_rsp_data, mem_req_wdata;
  logic [7:0] s_axi_wstrb = 8'hFF, mem_req_wstrb;
  logic [3:0] s_axi_rid, s_axi_bid;
  logic [1:0] s_axi_rresp, s_axi_bresp;
  logic s_axi_rlast, s_axi_rvalid, s_axi_arready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic mem_req_valid, mem_req_ready, mem_req_write, mem_rsp_valid, mem_rsp_err;
  logic ahb_arready, ahb_awready;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  fdas_row_t rows[7] = '{
    '{BURST_FIXED, 2'h3, 4'h3, 4'h1, 32'h100, 1'h0, 1'h0, RESP_OKAY},
    '{BURST_INCR, 2'h2, 4'h2, 4'h2, 32'h204, 1'h1, 1'h0, RESP_OKAY},
    '{BURST_WRAP, 2'h3, 4'h3, 4'h3, 32'h318, 1'h0, 1'h0, RESP_OKAY},
    '{BURST_INCR, 2'h0, 4'h1, 4'h9, 32'h601, 1'h0, 1'h0, RESP_OKAY},
    '{BURST_WRAP, 2'h1, 4'h1, 4'hA, 32'h702, 1'h1, 1'h0, RESP_OKAY},
    '{BURST_INCR, 2'h3, 4'hF, 4'h4, 32'h400, 1'h0, 1'h1, RESP_SLVERR},
    '{BURST_RSVD, 2'h0, 4'h1, 4'h5, 32'h500, 1'h0, 1'h0, RESP_SLVERR}};
  fdas_slave_port fdas_slave_port_i (.*);
  fdas_mem_model fdas_mem_model_i (.*);
  // a port built for the other bus sees the same requests and must never offer a handshake
  fdas_slave_port #(.BUS_MODE(FDAS_BUS_AHB)) fdas_slave_port_ahb_i (
    .*, .s_axi_arready(ahb_arready), .s_axi_awready(ahb_awready), .s_axi_rdata(),
    .s_axi_rid(), .s_axi_rresp(), .s_axi_rlast(), .s_axi_rvalid(), .s_axi_wready(),
    .s_axi_bid(), .s_axi_bresp(), .s_axi_bvalid(), .mem_req_valid(), .mem_req_write(),
    .mem_req_addr(), .mem_req_wdata(), .mem_req_wstrb(), .mem_req_ready(1'h0),
    .mem_rsp_valid(1'h0));
  always #12.5 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : chk
  // expected beat address, worked out independently of the design
  function automatic logic [31:0] nxt(input fdas_row_t r, input logic [31:0] a);
    logic [31:0] w, s;
    s = 32'h1 << r.sz;
    w = ({28'h0, r.ln} + 32'h1) << r.sz;
    if (r.b == BURST_FIXED) nxt = a;
    else if (r.b == BURST_WRAP) nxt = (a & ~(w - 32'h1)) | ((a + s) & (w - 32'h1));
    else nxt = (a & ~(s - 32'h1)) + s;
  endfunction : nxt
  task automatic rd(input fdas_row_t r);
    logic [31:0] x;
    x = r.a;
    @(negedge clock);
    s_axi_araddr = r.a;
    s_axi_arburst = r.b;
    s_axi_arid = r.id;
    s_axi_arsize = r.sz;
    s_axi_arlen = r.ln;
    s_axi_arvalid = 1'h1;
    #1 while (!s_axi_arready) @(negedge clock);
    chk("ahb_arready", 1'h0, ahb_arready);
    @(negedge clock);
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    for (int i = 0; i <= r.ln; i++) begin
      while (!s_axi_rvalid) @(negedge clock);
      if (i == 0) @(negedge clock);
      chk("rvalid", 1'h1, s_axi_rvalid);
      chk("rid", r.id, s_axi_rid);
      chk("rresp", r.rs, s_axi_rresp);
      chk("rlast", i == r.ln, s_axi_rlast);
      if (!r.err) chk("rdata", r.b == BURST_RSVD ? '0 : {~x, x}, s_axi_rdata);
      s_axi_rready = 1'h1;
      x = nxt(r, x);
      @(negedge clock);
    end
  endtask : rd
  task automatic wr(input logic [1:0] b, input logic [3:0] ln, id, input logic bad, rs);
    logic [31:0] wa;
    wa = {20'h0, id, 8'h00};
    @(negedge clock);
    {s_axi_awburst, s_axi_awsize, s_axi_awlen, s_axi_awid} = {b, 2'h3, ln, id};
    s_axi_awaddr = wa;
    s_axi_awvalid = 1'h1;
    #1 while (!s_axi_awready) @(negedge clock);
    chk("ahb_awready", 1'h0, ahb_awready);
    @(negedge clock);
    s_axi_awvalid = 1'h0;
    for (int i = 0; i <= ln; i++) begin
      s_axi_wvalid = 1'h1;
      s_axi_wdata = {32'h0, i};
      s_axi_wstrb = 8'hFF >> i;
      s_axi_wlast = (i == ln) ^ bad;
      #1 while (!s_axi_wready) @(negedge clock);
      @(negedge clock);
      // an accepted beat of a non-reserved burst now stands on the memory port until the memory takes it
      chk("mem_req_write", b != BURST_RSVD, mem_req_valid && mem_req_write);
      if (b != BURST_RSVD) begin
        chk("mem_req_addr", wa, mem_req_addr);
        chk("mem_req_wdata", {32'h0, i}, mem_req_wdata);
        chk("mem_req_wstrb", 8'hFF >> i, mem_req_wstrb);
      end
      wa = wa + 32'h8;
    end
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h1;
    while (!s_axi_bvalid) @(negedge clock);
    chk("bid", id, s_axi_bid);
    chk("bresp", {rs, 1'h0}, s_axi_bresp);
    @(negedge clock);
    s_axi_bready = 1'h0;
    chk("bvalid", 1'h0, s_axi_bvalid);
  endtask : wr
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clock);
    chk("rvalid", 1'h0, s_axi_rvalid);
    chk("bvalid", 1'h0, s_axi_bvalid);
    chk("wready", 1'h0, s_axi_wready);
    rst_b = 1'h1;
    foreach (rows[k]) begin
      slow = rows[k].slow;
      err_en = rows[k].err;
      rd(rows[k]);
    end
    err_en = 1'h0;
    wr(BURST_INCR, 4'h3, 4'h6, 1'h0, 1'h0);
    slow = 1'h1;
    wr(BURST_INCR, 4'h1, 4'h7, 1'h1, 1'h1);
    wr(BURST_RSVD, 4'h0, 4'h8, 1'h0, 1'h1);
    report_and_stop();
  end
endmodule : fabric_dram_axi_slave_port_tb
